// File: rtl/dpw_device.sv
// pwm device end: registers, two pwm channels, clock monitor, calibration
// Contract
// - on bit clear keeps channel off; duty (n+1)/256
// - delay field gives 32 times value periods
// - host writes duty and delay before enable; dpw_host forwards writes in user order
// - external clock divided 256, prescale 512
// - internal period times 256 is switching period
// - joint enable write synchronises external channels
// - bad external clock sets flag, pulls fault
// - after clock failure on bit drives output
// - recovery needs flag read and good clock
// - calibration word then measure chip select low
// - out-of-window pulse keeps previous period
// - host sets parallel bit, equal load profiles
// - parallel mirrors channel 1 inputs except diagnostics
// - parallel copies outputs on new data only
// - parallel uses channel 0 sense ratio
// - parallel overcurrent turns both off, both flagged
// - parallel severe short turns both off
// - parallel overtemperature turns both off
// - parallel shares channel 0 retry counter
// - open load and supply short per channel
// - each channel has its own pwm logic in a gen_ch block
// - duty register holds on bit and value
`timescale 1ns/1ps
module dpw_device #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// link
	dpw_if.device link,
	// analog fault detectors per channel
	input wire logic [1:0] oc_det_in,
	input wire logic [1:0] sc_det_in,
	input wire logic [1:0] ot_det_in,
	input wire logic [1:0] open_load_on_flag_det_in,
	input wire logic [1:0] open_load_off_flag_det_in,
	input wire logic [1:0] os_det_in,
	// channel 0 retry counter from protection logic
	input wire logic [3:0] retry_cnt_in,
	// switch drives
	output logic [1:0] high_side_output_out,
	output logic [1:0] sense_ratio_out
);
	initial begin
		if (CNT_W < 16) $error("dpw_device: CNT_W too small");
	end

	logic [8:0] duty_cycle_register [2];
	logic [8:0] channel_config_register [2];
	logic [8:0] overcurrent_config_register [2];
	logic [8:0] global_control_register;
	logic [8:0] fault_report_register [2];
	logic [8:0] retry_count_register [2];
	logic clk_fail;
	logic clk_fail_flag;
	logic parallel;
	logic [1:0] pwm_en;
	logic wr_en_any;

	// synchronisers for pins
	logic [2:0] xclk_s;
	logic [2:0] csb_s;
	logic [15:0] det_s1;
	logic [15:0] det_s2;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			xclk_s <= 3'h0;
			csb_s <= 3'h7;
		end else begin
			xclk_s <= {xclk_s[1:0], link.ext_clock};
			csb_s <= {csb_s[1:0], link.csb_n};
		end
	end
	wire xclk_rise = xclk_s[1] & ~xclk_s[2];
	wire csb_fall = ~csb_s[1] & csb_s[2];
	wire csb_rise = csb_s[1] & ~csb_s[2];
	// detector and retry pins, two flops before use
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			det_s1 <= 16'h0000;
			det_s2 <= 16'h0000;
		end else begin
			det_s1 <= {retry_cnt_in, os_det_in, open_load_off_flag_det_in, open_load_on_flag_det_in, ot_det_in, sc_det_in,
				oc_det_in};
			det_s2 <= det_s1;
		end
	end
	wire [1:0] oc_s = det_s2[1:0];
	wire [1:0] sc_s = det_s2[3:2];
	wire [1:0] ot_s = det_s2[5:4];
	wire [1:0] open_load_on_flag_s = det_s2[7:6];
	wire [1:0] open_load_off_flag_s = det_s2[9:8];
	wire [1:0] os_s = det_s2[11:10];
	wire [3:0] retry_s = det_s2[15:12];

	assign parallel = global_control_register[dpw_pkg::GCR_PAR_BIT];
	assign pwm_en = {global_control_register[dpw_pkg::GCR_EN1_BIT],
		global_control_register[dpw_pkg::GCR_EN0_BIT]};
	wire wr = link.wr_stb;
	wire [3:0] a = link.addr;

	// input registers, channel 1 mirrored from channel 0 in parallel except config bits 8:6
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			duty_cycle_register[0] <= dpw_pkg::REG_RESET;
			duty_cycle_register[1] <= dpw_pkg::REG_RESET;
			channel_config_register[0] <= dpw_pkg::REG_RESET;
			channel_config_register[1] <= dpw_pkg::REG_RESET;
			overcurrent_config_register[0] <= dpw_pkg::REG_RESET;
			overcurrent_config_register[1] <= dpw_pkg::REG_RESET;
			global_control_register <= dpw_pkg::REG_RESET;
		end else begin
			if (wr && a == dpw_pkg::REG_DUTY0) duty_cycle_register[0] <= link.wdata;
			if (wr && a == dpw_pkg::REG_CONF0) channel_config_register[0] <= link.wdata;
			if (wr && a == dpw_pkg::REG_OCR0) overcurrent_config_register[0] <= link.wdata;
			if (wr && a == dpw_pkg::REG_GCR) global_control_register <= link.wdata;
			if (parallel) begin
				duty_cycle_register[1] <= duty_cycle_register[0];
				overcurrent_config_register[1] <= overcurrent_config_register[0];
				channel_config_register[1][5:0] <= channel_config_register[0][5:0];
				if (wr && a == dpw_pkg::REG_CONF1)
					channel_config_register[1][8:6] <= link.wdata[8:6];
			end else begin
				if (wr && a == dpw_pkg::REG_DUTY1) duty_cycle_register[1] <= link.wdata;
				if (wr && a == dpw_pkg::REG_CONF1) channel_config_register[1] <= link.wdata;
				if (wr && a == dpw_pkg::REG_OCR1) overcurrent_config_register[1] <= link.wdata;
			end
		end
	end
	// channel 0 sense ratio governs both in parallel
	assign sense_ratio_out = {overcurrent_config_register[1][dpw_pkg::SENSE_BIT],
		overcurrent_config_register[0][dpw_pkg::SENSE_BIT]};

	// external clock monitor on rising-edge spacing
	logic [CNT_W-1:0] xper;
	logic xbad;
	wire mon_act = |(pwm_en & ~{overcurrent_config_register[1][dpw_pkg::CLK_INT_BIT],
		overcurrent_config_register[0][dpw_pkg::CLK_INT_BIT]});
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			xper <= '0;
			xbad <= 1'b0;
		end else if (!mon_act) begin
			xper <= '0;
			xbad <= 1'b0;
		end else if (xclk_rise) begin
			xper <= '0;
			xbad <= (xper < CNT_W'(dpw_pkg::EXT_MIN_CYC));
		end else if (xper >= CNT_W'(dpw_pkg::EXT_MAX_CYC)) begin
			xbad <= 1'b1;
		end else begin
			xper <= xper + 1'b1;
		end
	end
	wire rd_diag = link.rd_stb && a == dpw_pkg::REG_DIAG;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			clk_fail_flag <= 1'b0;
			clk_fail <= 1'b0;
		end else begin
			if (xbad) clk_fail_flag <= 1'b1;
			else if (rd_diag) clk_fail_flag <= 1'b0;
			if (xbad) clk_fail <= 1'b1;
			else if (!clk_fail_flag || rd_diag) clk_fail <= 1'b0;
		end
	end

	// calibration of the internal clock period
	dpw_pkg::dpw_cal_t cal_st;
	logic [CNT_W-1:0] cal_cnt;
	logic [CNT_W-1:0] int_per;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cal_st <= dpw_pkg::DPW_CAL_IDLE;
			cal_cnt <= '0;
			int_per <= CNT_W'(dpw_pkg::INT_PER_DEF_CYC);
		end else begin
			unique case (cal_st)
				dpw_pkg::DPW_CAL_IDLE: begin
					if (wr && a == dpw_pkg::REG_CAL && link.wdata == dpw_pkg::CAL_WORD)
						cal_st <= dpw_pkg::DPW_CAL_ARMED;
				end
				dpw_pkg::DPW_CAL_ARMED: begin
					cal_cnt <= '0;
					if (csb_fall) cal_st <= dpw_pkg::DPW_CAL_MEAS;
				end
				dpw_pkg::DPW_CAL_MEAS: begin
					if (cal_cnt != '1) cal_cnt <= cal_cnt + 1'b1;
					if (csb_rise) begin
						cal_st <= dpw_pkg::DPW_CAL_IDLE;
						if (cal_cnt >= CNT_W'(dpw_pkg::CSB_MIN_CYC) &&
							cal_cnt <= CNT_W'(dpw_pkg::CSB_MAX_CYC))
							int_per <= cal_cnt >> 6;
					end
				end
				default: cal_st <= dpw_pkg::DPW_CAL_IDLE;
			endcase
		end
	end

	// shared protection: either channel trips both in parallel
	wire [1:0] oc_eff = parallel ? {2{|oc_s}} : oc_s;
	wire [1:0] sc_eff = parallel ? {2{|sc_s}} : sc_s;
	wire [1:0] ot_eff = parallel ? {2{|ot_s}} : ot_s;
	wire [1:0] trip = oc_eff | sc_eff | ot_eff;

	assign wr_en_any = wr && a == dpw_pkg::REG_GCR;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_ch
			wire clk_int = overcurrent_config_register[g][dpw_pkg::CLK_INT_BIT];
			wire pre = overcurrent_config_register[g][dpw_pkg::PRESCALE_BIT];
			wire [8:0] dr = duty_cycle_register[g];
			wire en_bit = pwm_en[g];
			wire en_new = wr_en_any && link.wdata[dpw_pkg::GCR_EN0_BIT + g] && !en_bit;
			logic [CNT_W-1:0] ipre;
			logic tick;
			logic [8:0] phase;
			logic [7:0] dly;
			logic run;
			logic out;
			wire ext_use = !clk_int && !clk_fail;
			always_ff @(posedge clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					ipre <= '0;
					tick <= 1'b0;
				end else begin
					tick <= 1'b0;
					if (clk_int) begin
						if (ipre + 1'b1 >= int_per) begin
							ipre <= '0;
							tick <= 1'b1;
						end else begin
							ipre <= ipre + 1'b1;
						end
					end else begin
						ipre <= '0;
						tick <= ext_use && xclk_rise;
					end
				end
			end
			always_ff @(posedge clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					phase <= '0;
					dly <= '0;
					run <= 1'b0;
				end else if (!en_bit || en_new) begin
					phase <= '0;
					run <= 1'b0;
					dly <= 8'(channel_config_register[g][dpw_pkg::DLY_LSB +: 3] *
						dpw_pkg::DLY_STEP);
				end else if (tick) begin
					if (!run) begin
						if (dly == 8'h00) run <= 1'b1;
						else dly <= dly - 8'h01;
					end else if (pre) begin
						phase <= phase + 9'h001;
					end else begin
						phase <= {1'b0, phase[7:0] + 8'h01};
					end
				end
			end
			wire [7:0] pos = pre ? phase[8:1] : phase[7:0];
			always_ff @(posedge clk_in or negedge nrst_in) begin
				if (!nrst_in) out <= 1'b0;
				else if (trip[g]) out <= 1'b0;
				else if (!dr[dpw_pkg::ON_BIT]) out <= 1'b0;
				else if (!en_bit || (clk_fail && !clk_int)) out <= 1'b1;
				else out <= run && ({1'b0, pos} <= {1'b0, dr[7:0]});
			end
			assign high_side_output_out[g] = out;
		end
	endgenerate

	// fault report registers, set wins over read-clear
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			fault_report_register[0] <= dpw_pkg::REG_RESET;
			fault_report_register[1] <= dpw_pkg::REG_RESET;
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (link.rd_stb && a == 4'(dpw_pkg::REG_FAULT0 + c))
					fault_report_register[c] <= dpw_pkg::REG_RESET;
				if (oc_eff[c]) fault_report_register[c][dpw_pkg::OD_OC] <= 1'b1;
				if (sc_eff[c]) fault_report_register[c][dpw_pkg::OD_SC] <= 1'b1;
				if (ot_eff[c]) fault_report_register[c][dpw_pkg::OD_OT] <= 1'b1;
				if (os_s[c] && channel_config_register[c][8])
					fault_report_register[c][3] <= 1'b1;
				if (open_load_on_flag_s[c] && channel_config_register[c][7])
					fault_report_register[c][4] <= 1'b1;
				if (open_load_off_flag_s[c] && channel_config_register[c][6])
					fault_report_register[c][5] <= 1'b1;
			end
		end
	end
	// retry registers: channel 1 copy refreshed on new channel 0 value
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			retry_count_register[0] <= dpw_pkg::REG_RESET;
			retry_count_register[1] <= dpw_pkg::REG_RESET;
		end else begin
			retry_count_register[0][dpw_pkg::OD_RETRY_LSB +: 4] <= retry_s;
			if (parallel && retry_count_register[0][dpw_pkg::OD_RETRY_LSB +: 4] != retry_s)
				retry_count_register[1][dpw_pkg::OD_RETRY_LSB +: 4] <= retry_s;
		end
	end

	assign link.fault_oe = clk_fail | (|trip);
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) link.rdata <= '0;
		else begin
			unique case (a)
				dpw_pkg::REG_DUTY0: link.rdata <= duty_cycle_register[0];
				dpw_pkg::REG_DUTY1: link.rdata <= duty_cycle_register[1];
				dpw_pkg::REG_CONF0: link.rdata <= channel_config_register[0];
				dpw_pkg::REG_CONF1: link.rdata <= channel_config_register[1];
				dpw_pkg::REG_OCR0: link.rdata <= overcurrent_config_register[0];
				dpw_pkg::REG_OCR1: link.rdata <= overcurrent_config_register[1];
				dpw_pkg::REG_GCR: link.rdata <= global_control_register;
				dpw_pkg::REG_DIAG: link.rdata <= 9'(clk_fail_flag) << dpw_pkg::OD_CLKFAIL;
				dpw_pkg::REG_FAULT0: link.rdata <= fault_report_register[0];
				dpw_pkg::REG_FAULT1: link.rdata <= fault_report_register[1];
				dpw_pkg::REG_RETRY0: link.rdata <= retry_count_register[0];
				dpw_pkg::REG_RETRY1: link.rdata <= retry_count_register[1];
				default: link.rdata <= '0;
			endcase
		end
	end
endmodule // dpw_device

// File: rtl/dpw_host.sv
// host end: forwards register requests and drives clock and chip select
`timescale 1ns/1ps
module dpw_host #(
	parameter int EXT_DIV = 200
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// user request
	input wire logic req_in,
	input wire logic [3:0] addr_in,
	input wire logic [8:0] data_in,
	input wire logic rd_in,
	input wire logic [1:0] profile_in,
	input wire logic csb_n_in,
	// user answer
	output logic busy_out,
	output logic [8:0] rdata_out,
	output logic fault_n_out,
	// link
	dpw_if.host link
);
	initial begin
		if (EXT_DIV < 2) $error("dpw_host: EXT_DIV too small");
	end
	logic [15:0] div;
	logic xclk;
	logic [1:0] rd_pend;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			div <= '0;
			xclk <= 1'b0;
		end else if (div >= 16'(EXT_DIV / 2 - 1)) begin
			div <= '0;
			xclk <= ~xclk;
		end else begin
			div <= div + 16'h0001;
		end
	end
	// duty and delay go before the enable word; this block forwards requests in user order
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			link.wr_stb <= 1'b0;
			link.rd_stb <= 1'b0;
			link.addr <= '0;
			link.wdata <= '0;
			link.csb_n <= 1'b1;
			link.load_profile_select <= '0;
			rd_pend <= '0;
			rdata_out <= '0;
		end else begin
			link.wr_stb <= req_in && !rd_in;
			link.rd_stb <= req_in && rd_in;
			if (req_in) begin
				link.addr <= addr_in;
				link.wdata <= data_in;
			end
			link.csb_n <= csb_n_in;
			link.load_profile_select <= {2{profile_in[0]}};
			rd_pend <= {rd_pend[0], req_in && rd_in};
			if (rd_pend[1]) rdata_out <= link.rdata;
		end
	end
	assign link.ext_clock = xclk;
	assign busy_out = link.wr_stb | link.rd_stb;
	assign fault_n_out = link.fault_n;
endmodule // dpw_host

// File: rtl/dpw_if.sv
// link between host controller and pwm device
`timescale 1ns/1ps
interface dpw_if;
	// register port
	logic wr_stb;
	logic rd_stb;
	logic [3:0] addr;
	logic [8:0] wdata;
	logic [8:0] rdata;
	// chip select used for calibration, active low
	logic csb_n;
	// external time base
	logic ext_clock;
	// fault pin, open drain
	logic fault_oe;
	logic fault_n;
	// load profile straps
	logic [1:0] load_profile_select;
	assign fault_n = ~fault_oe;
	modport device (
		input wr_stb, rd_stb, addr, wdata, csb_n, ext_clock, load_profile_select, fault_n,
		output rdata, fault_oe
	);
	modport host (
		output wr_stb, rd_stb, addr, wdata, csb_n, ext_clock, load_profile_select,
		input rdata, fault_n
	);
endinterface // dpw_if

// File: rtl/dpw_pkg.sv
// shared constants and types for the dual-channel pwm block
package dpw_pkg;
	// register indices on the configuration port
	localparam logic [3:0] REG_DUTY0 = 4'h0;
	localparam logic [3:0] REG_DUTY1 = 4'h1;
	localparam logic [3:0] REG_CONF0 = 4'h2;
	localparam logic [3:0] REG_CONF1 = 4'h3;
	localparam logic [3:0] REG_OCR0 = 4'h4;
	localparam logic [3:0] REG_OCR1 = 4'h5;
	localparam logic [3:0] REG_GCR = 4'h6;
	localparam logic [3:0] REG_CAL = 4'h7;
	localparam logic [3:0] REG_DIAG = 4'h8;
	localparam logic [3:0] REG_FAULT0 = 4'h9;
	localparam logic [3:0] REG_FAULT1 = 4'ha;
	localparam logic [3:0] REG_RETRY0 = 4'hb;
	localparam logic [3:0] REG_RETRY1 = 4'hc;
	// field positions
	localparam int ON_BIT = 8;
	localparam int DLY_LSB = 0;
	localparam int LOAD_PROFILE_SELECT_DIAG_LSB = 6;
	localparam int SENSE_BIT = 5;
	localparam int CLK_INT_BIT = 6;
	localparam int PRESCALE_BIT = 7;
	localparam int GCR_EN0_BIT = 7;
	localparam int GCR_EN1_BIT = 8;
	localparam int GCR_PAR_BIT = 6;
	localparam int OD_OC = 0;
	localparam int OD_SC = 1;
	localparam int OD_OT = 2;
	localparam int OD_CLKFAIL = 2;
	localparam int OD_RETRY_LSB = 4;
	// values
	localparam logic [8:0] REG_RESET = 9'h000;
	localparam logic [8:0] CAL_WORD = 9'h155;
	localparam int DLY_STEP = 32;
	localparam int PWM_STEPS = 256;
	// external clock window, ns
	localparam int EXT_PER_MIN_NS = 500;
	localparam int EXT_PER_MAX_NS = 40000;
	localparam int CLK_NS = 10;
	localparam int EXT_MIN_CYC = (EXT_PER_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int EXT_MAX_CYC = EXT_PER_MAX_NS / CLK_NS;
	// calibration window, ns, and default internal period, cycles
	localparam int CSB_MIN_NS = 1000;
	localparam int CSB_MAX_NS = 40000;
	localparam int CSB_MIN_CYC = (CSB_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int CSB_MAX_CYC = CSB_MAX_NS / CLK_NS;
	localparam int INT_PER_DEF_CYC = 200;
	typedef enum logic [1:0] {
		DPW_CAL_IDLE = 2'b00,
		DPW_CAL_ARMED = 2'b01,
		DPW_CAL_MEAS = 2'b11
	} dpw_cal_t;
endpackage // dpw_pkg

// File: tb/dpw_checker.sv
// assertion checker on the link between host and device
`timescale 1ns/1ps
module dpw_checker (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// link signals
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [3:0] addr,
	input wire logic [8:0] wdata,
	input wire logic [8:0] rdata,
	input wire logic fault_oe
);
	logic [8:0] shadow [0:6];
	logic [8:0] rd_exp;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);
	// copy of every writable configuration register
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			shadow <= '{default: dpw_pkg::REG_RESET};
		else if (wr_stb && addr <= dpw_pkg::REG_GCR)
			shadow[addr[2:0]] <= wdata;
	end
	// value a read should return
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			rd_exp <= dpw_pkg::REG_RESET;
		else if (rd_stb && addr <= dpw_pkg::REG_GCR)
			rd_exp <= shadow[addr[2:0]];
	end
	duty0_readback_a: assert property (rd_stb && addr == dpw_pkg::REG_DUTY0 |=> rdata == rd_exp)
		else $error("duty 0 readback wrong");
	duty1_readback_a: assert property (rd_stb && addr == dpw_pkg::REG_DUTY1 |=> rdata == rd_exp)
		else $error("duty 1 readback wrong");
	conf0_readback_a: assert property (rd_stb && addr == dpw_pkg::REG_CONF0 |=>
		(rdata & 9'h1c7) == (rd_exp & 9'h1c7)) else $error("config 0 readback wrong");
	conf1_readback_a: assert property (rd_stb && addr == dpw_pkg::REG_CONF1 |=>
		(rdata & 9'h1c7) == (rd_exp & 9'h1c7)) else $error("config 1 readback wrong");
	ocr0_readback_a: assert property (rd_stb && addr == dpw_pkg::REG_OCR0 |=>
		(rdata & 9'h0e0) == (rd_exp & 9'h0e0)) else $error("overcurrent 0 readback wrong");
	ocr1_readback_a: assert property (rd_stb && addr == dpw_pkg::REG_OCR1 |=>
		(rdata & 9'h0e0) == (rd_exp & 9'h0e0)) else $error("overcurrent 1 readback wrong");
	gcr_readback_a: assert property (rd_stb && addr == dpw_pkg::REG_GCR |=>
		rdata[8:7] == rd_exp[8:7]) else $error("enable bits readback wrong");
	stb_pulse_a: assert property (wr_stb |=> !wr_stb)
		else $error("write strobe longer than one cycle");
	stb_apart_a: assert property (!(wr_stb && rd_stb))
		else $error("read and write strobes together");
	cover property (wr_stb && addr == dpw_pkg::REG_CAL && wdata == dpw_pkg::CAL_WORD);
	cover property (wr_stb && addr == dpw_pkg::REG_GCR && wdata[8:7] == 2'b11);
	cover property (rd_stb && addr == dpw_pkg::REG_FAULT0);
	cover property ($rose(fault_oe));
endmodule // dpw_checker

// File: tb/dual_channel_pwm_parallel_control_bench.sv
// self-checking bench: host and device joined by a link, plus a bench-driven device
`timescale 1ns/1ps
module dual_channel_pwm_parallel_control_bench;
	logic clk_in;
	logic nrst_in;
	logic req_in;
	logic [3:0] addr_in;
	logic [8:0] data_in;
	logic rd_in;
	logic csb_n_in;
	logic busy_out;
	logic [8:0] rdata_out;
	logic fault_n_out;
	logic [1:0] hs_a, hs_b, sense_a, sense_b;
	logic [1:0] oc_d, sc_d, ot_d, open_load_on_flag_d, open_load_off_flag_d, os_d;
	logic [3:0] retry_d;
	logic clk_b_run;
	logic [8:0] rv;
	int miscompares;
	int samples_checked;
	int n, cnt, lat0;
	int bcnt = 0;
	dpw_if link_a();
	dpw_if link_b();
	dpw_host #(.EXT_DIV(100)) dpw_host_inst (.clk_in(clk_in), .nrst_in(nrst_in), .req_in(req_in),
		.addr_in(addr_in), .data_in(data_in), .rd_in(rd_in), .profile_in(2'h1),
		.csb_n_in(csb_n_in), .busy_out(busy_out), .rdata_out(rdata_out),
		.fault_n_out(fault_n_out), .link(link_a));
	dpw_device dpw_device_inst (.clk_in(clk_in), .nrst_in(nrst_in), .link(link_a),
		.oc_det_in(oc_d), .sc_det_in(sc_d), .ot_det_in(ot_d), .open_load_on_flag_det_in(open_load_on_flag_d),
		.open_load_off_flag_det_in(open_load_off_flag_d), .os_det_in(os_d), .retry_cnt_in(retry_d),
		.high_side_output_out(hs_a), .sense_ratio_out(sense_a));
	dpw_device dpw_device_b_inst (.clk_in(clk_in), .nrst_in(nrst_in), .link(link_b),
		.oc_det_in(oc_d), .sc_det_in(sc_d), .ot_det_in(ot_d), .open_load_on_flag_det_in(open_load_on_flag_d),
		.open_load_off_flag_det_in(open_load_off_flag_d), .os_det_in(os_d), .retry_cnt_in(retry_d),
		.high_side_output_out(hs_b), .sense_ratio_out(sense_b));
	dpw_checker dpw_checker_inst (.clk_in(clk_in), .nrst_in(nrst_in), .wr_stb(link_a.wr_stb),
		.rd_stb(link_a.rd_stb), .addr(link_a.addr), .wdata(link_a.wdata),
		.rdata(link_a.rdata), .fault_oe(link_a.fault_oe));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// external time base of the bench-driven device, 1 us period, stops when told
	always @(posedge clk_in) begin
		bcnt <= (bcnt == 49) ? 0 : bcnt + 1;
		if (!nrst_in)
			link_b.ext_clock <= 1'b0;
		else if (clk_b_run && bcnt == 49)
			link_b.ext_clock <= ~link_b.ext_clock;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (miscompares == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// one request through the host user port, waits for busy to drop
	task automatic host_op(input logic rd, input logic [3:0] a, input logic [8:0] d);
		@(posedge clk_in);
		req_in <= 1'b1;
		rd_in <= rd;
		addr_in <= a;
		data_in <= d;
		@(posedge clk_in);
		req_in <= 1'b0;
		#1;
		for (n = 0; n < 50 && busy_out !== 1'b0; n++)
			@(posedge clk_in) #1;
		repeat (2) @(posedge clk_in);
		#1 rv = rdata_out;
	endtask
	// one strobe cycle on the bench-driven link, read data taken a cycle later
	task automatic b_op(input logic rd, input logic [3:0] a, input logic [8:0] d);
		@(posedge clk_in);
		link_b.wr_stb <= !rd;
		link_b.rd_stb <= rd;
		link_b.addr <= a;
		link_b.wdata <= d;
		@(posedge clk_in);
		link_b.wr_stb <= 1'b0;
		link_b.rd_stb <= 1'b0;
		#1 rv = link_b.rdata;
	endtask
	task automatic calibrate(input int low_cycles);
		host_op(1'b0, dpw_pkg::REG_CAL, dpw_pkg::CAL_WORD);
		@(posedge clk_in);
		csb_n_in <= 1'b0;
		repeat (low_cycles) @(posedge clk_in);
		csb_n_in <= 1'b1;
		repeat (20) @(posedge clk_in);
	endtask
	task automatic duty_run(input logic [8:0] duty, input int exp);
		host_op(1'b0, dpw_pkg::REG_DUTY0, duty);
		repeat (1100) @(posedge clk_in);
		cnt = 0;
		repeat (2048) begin
			@(posedge clk_in) #1;
			cnt += hs_a[0];
		end
		check(cnt[15:0], exp[15:0]);
	endtask
	task automatic delay_run(input logic [2:0] dly, output int lat);
		host_op(1'b0, dpw_pkg::REG_GCR, 9'h000);
		host_op(1'b0, dpw_pkg::REG_CONF0, {6'h00, dly});
		host_op(1'b0, dpw_pkg::REG_GCR, 9'h080);
		for (lat = 0; lat < 3000 && hs_a[0] !== 1'b1; lat++)
			@(posedge clk_in) #1;
	endtask
	initial begin
		#900000;
		miscompares++;
		print_verdict();
	end
	initial begin
		nrst_in = 1'b0;
		req_in = 1'b0;
		rd_in = 1'b0;
		addr_in = 4'h0;
		data_in = 9'h000;
		csb_n_in = 1'b1;
		{oc_d, sc_d, ot_d, open_load_on_flag_d, open_load_off_flag_d, os_d} = 12'h000;
		retry_d = 4'h3;
		clk_b_run = 1'b0;
		miscompares = 0;
		samples_checked = 0;
		link_b.wr_stb = 1'b0;
		link_b.rd_stb = 1'b0;
		link_b.addr = 4'h0;
		link_b.wdata = 9'h000;
		link_b.csb_n = 1'b1;
		link_b.load_profile_select = 2'h1;
		repeat (4) @(posedge clk_in);
		nrst_in <= 1'b1;
		host_op(1'b0, dpw_pkg::REG_DUTY1, 9'h1a5);
		host_op(1'b1, dpw_pkg::REG_DUTY1, 9'h000);
		check({7'h00, rv}, 16'h01a5);
		host_op(1'b0, dpw_pkg::REG_OCR1, 9'h0e0);
		host_op(1'b1, dpw_pkg::REG_OCR1, 9'h000);
		check({7'h00, rv & 9'h0e0}, 16'h00e0);
		check({14'h0000, sense_a}, 16'h0002);
		// internal period of two cycles: pwm period 512 cycles
		calibrate(160);
		host_op(1'b0, dpw_pkg::REG_OCR0, 9'h040);
		host_op(1'b0, dpw_pkg::REG_CONF0, 9'h000);
		host_op(1'b0, dpw_pkg::REG_GCR, 9'h080);
		duty_run(9'h000, 0);
		duty_run(9'h100, 8);
		duty_run(9'h13f, 512);
		duty_run(9'h1ff, 2048);
		calibrate(50);
		duty_run(9'h13f, 512);
		delay_run(3'h0, lat0);
		delay_run(3'h3, cnt);
		check({15'h0000, (cnt - lat0 >= 188) && (cnt - lat0 <= 196)}, 16'h0001);
		// both channels on the external clock, enabled in one write
		host_op(1'b0, dpw_pkg::REG_GCR, 9'h000);
		host_op(1'b0, dpw_pkg::REG_OCR0, 9'h000);
		host_op(1'b0, dpw_pkg::REG_OCR1, 9'h000);
		host_op(1'b0, dpw_pkg::REG_CONF0, 9'h000);
		host_op(1'b0, dpw_pkg::REG_DUTY1, 9'h1ff);
		host_op(1'b0, dpw_pkg::REG_GCR, 9'h180);
		for (n = 0; n < 30000 && hs_a === 2'b00; n++)
			@(posedge clk_in) #1;
		check({14'h0000, hs_a}, 16'h0003);
		// supply short reported on its own channel only
		host_op(1'b0, dpw_pkg::REG_CONF0, 9'h100);
		os_d <= 2'b01;
		repeat (20) @(posedge clk_in);
		host_op(1'b1, dpw_pkg::REG_FAULT0, 9'h000);
		check({15'h0000, rv[3]}, 16'h0001);
		host_op(1'b1, dpw_pkg::REG_FAULT1, 9'h000);
		check({15'h0000, rv[3]}, 16'h0000);
		os_d <= 2'b00;
		// external clock stands still on the second device
		b_op(1'b0, dpw_pkg::REG_DUTY0, 9'h100);
		b_op(1'b0, dpw_pkg::REG_OCR0, 9'h000);
		b_op(1'b0, dpw_pkg::REG_GCR, 9'h080);
		for (n = 0; n < 6000 && link_b.fault_oe !== 1'b1; n++)
			@(posedge clk_in) #1;
		check({15'h0000, link_b.fault_n}, 16'h0000);
		repeat (10) @(posedge clk_in);
		check({15'h0000, hs_b[0]}, 16'h0001);
		b_op(1'b1, dpw_pkg::REG_DIAG, 9'h000);
		check({15'h0000, rv[dpw_pkg::OD_CLKFAIL]}, 16'h0001);
		repeat (20) @(posedge clk_in);
		check({15'h0000, link_b.fault_oe}, 16'h0001);
		clk_b_run <= 1'b1;
		repeat (1000) @(posedge clk_in);
		b_op(1'b1, dpw_pkg::REG_DIAG, 9'h000);
		for (n = 0; n < 9000 && link_b.fault_oe !== 1'b0; n++)
			@(posedge clk_in) #1;
		check({15'h0000, link_b.fault_oe}, 16'h0000);
		// parallel mode on the second device
		b_op(1'b0, dpw_pkg::REG_GCR, 9'h040);
		b_op(1'b0, dpw_pkg::REG_DUTY0, 9'h1a5);
		b_op(1'b1, dpw_pkg::REG_DUTY1, 9'h000);
		check({7'h00, rv}, 16'h01a5);
		check({14'h0000, hs_b}, 16'h0003);
		retry_d <= 4'h5;
		oc_d <= 2'b10;
		repeat (8) @(posedge clk_in);
		#1 check({14'h0000, hs_b}, 16'h0000);
		b_op(1'b1, dpw_pkg::REG_FAULT0, 9'h000);
		check({15'h0000, rv[dpw_pkg::OD_OC]}, 16'h0001);
		b_op(1'b1, dpw_pkg::REG_RETRY1, 9'h000);
		check({12'h000, rv[7:4]}, 16'h0005);
		oc_d <= 2'b00;
		print_verdict();
	end
endmodule // dual_channel_pwm_parallel_control_bench
